/* File: rtl/tmc_pkg.sv */
package tmc_pkg;
    // Register byte offsets on the APB word map
    localparam logic [7:0] ADDR_CNT_LO = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CLKCTL = 8'h10;
    localparam logic [7:0] ADDR_IEN = 8'h14;
    localparam logic [7:0] ADDR_CPUFLAG = 8'h18;
    localparam logic [7:0] ADDR_CHCTL0 = 8'h1C;
    localparam logic [7:0] ADDR_CHVAL0 = 8'h28;
    localparam int NUM_CH = 3;
    localparam int CHCTL_W = 7;

    // timer_control_reg fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIV_LSB = 2;
    localparam int CTRL_WRAP_BIT = 4;
    localparam int CTRL_CHF_LSB = 5;

    // channel_control_reg fields
    localparam int CH_EDGE_LSB = 0;
    localparam int CH_CMPEN_BIT = 2;
    localparam int CH_ACT_LSB = 3;
    localparam int CH_IM_BIT = 6;

    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam logic [2:0] TSS_RESET = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Prescale terminal counts for divide by 1, 8, 32, 128
    localparam logic [6:0] PRE_DIV1 = 7'h00;
    localparam logic [6:0] PRE_DIV8 = 7'h07;
    localparam logic [6:0] PRE_DIV32 = 7'h1F;
    localparam logic [6:0] PRE_DIV128 = 7'h7F;

    typedef enum logic [1:0] {
        MODE_HALT = 2'h0,
        MODE_FREE = 2'h1,
        MODE_MODULO = 2'h2,
        MODE_UPDOWN = 2'h3
    } tmc_mode_t;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY = 2'h3
    } tmc_edge_t;

    typedef enum logic [2:0] {
        ACT_SET = 3'h0,
        ACT_CLEAR = 3'h1,
        ACT_TOGGLE = 3'h2
    } tmc_act_t;
endpackage : tmc_pkg

/* File: rtl/tmc_tick_gen.sv */
`timescale 1ns/1ps
module tmc_tick_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] tick_speed_select,
    input wire logic [1:0] div_sel,
    input wire logic run,
    output logic edge_en
);
    typedef struct packed {
        logic [6:0] tdiv;
        logic [6:0] pre;
    } tmc_tick_st_t;

    tmc_tick_st_t st_r;
    tmc_tick_st_t st_nxt;
    logic tick;
    logic [6:0] pre_term;

    always_comb begin
        st_nxt = st_r;
        tick = 1'b0;
        edge_en = 1'b0;
        unique case (div_sel)
            2'h0: pre_term = tmc_pkg::PRE_DIV1;
            2'h1: pre_term = tmc_pkg::PRE_DIV8;
            2'h2: pre_term = tmc_pkg::PRE_DIV32;
            2'h3: pre_term = tmc_pkg::PRE_DIV128;
        endcase
        // Tick is an enable pulse; pclk itself is never slowed
        if (st_r.tdiv >= ((7'h01 << tick_speed_select) - 7'h01)) begin
            st_nxt.tdiv = 7'h00;
            tick = 1'b1;
        end else begin
            st_nxt.tdiv = st_r.tdiv + 7'h01;
        end
        if (!run) begin
            st_nxt.pre = 7'h00;
        end else if (tick) begin
            if (st_r.pre >= pre_term) begin
                st_nxt.pre = 7'h00;
                edge_en = 1'b1;
            end else begin
                st_nxt.pre = st_r.pre + 7'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : tmc_tick_gen

/* File: rtl/tmc_timer.sv */
// Functional notes
// - The tick is divided by a prescale of 1, 8, 32 or 128 to give counting edges.
// - The tick comes from a tick divider and never changes the system clock.
// - A 16-bit counter steps by one, up or down by mode, on each counting edge.
// - Reading the low count byte latches the high byte for the high byte register.
// - Any write to the low count byte clears the whole counter.
// - A nonzero mode starts the counter; mode 00 halts it at its present value.
// - Free-running mode counts from 0x0000 to 0xFFFF then wraps to 0x0000.
// - Free-running mode sets the wrap flag when the counter reaches 0xFFFF.
// - Modulo mode counts from 0x0000 to the terminal value then loads 0x0000.
// - Modulo mode sets the wrap flag when the counter reaches the terminal value.
// - Up/down mode counts up to the terminal value, down to 0x0000, and repeats.
// - Up/down mode sets the wrap flag on return to 0x0000, not at the top.
// - A wrap reaches the CPU flag through the wrap mask, or in up/down mode via the channel 0 mask if its compare is on; a request needs that flag and the enable.
// - Three capture/compare channels, each with one pin and a control register.
`timescale 1ns/1ps
module tmc_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] ch_pin_in,
    output logic [2:0] ch_pin_out,
    output logic [2:0] ch_pin_oe_n,
    output logic irq_req
);
    typedef struct packed {
        logic [15:0] cnt;
        logic down;
        logic [1:0] mode;
        logic [1:0] div;
        logic wrap_flag;
        logic [2:0] ch_flag;
        logic wrap_irq_mask;
        logic [2:0] tick_speed_select;
        logic timer_irq_enable;
        logic timer_cpu_flag;
        logic [7:0] hi_buf;
        logic [2:0][6:0] chctl;
        logic [2:0][15:0] chval;
        logic [2:0][7:0] lo_buf;
        logic [2:0] sync0;
        logic [2:0] sync1;
        logic [2:0] sprev;
        logic [2:0] pout;
        logic [31:0] rdata;
    } tmc_state_t;

    tmc_state_t st_r;
    tmc_state_t st_nxt;
    logic edge_en;
    logic running;
    logic wr_acc;
    logic rd_setup;
    logic [15:0] term;
    logic [15:0] cnt_step;
    logic wrap_evt;
    logic [2:0] ch_evt;
    logic [2:0] cap_evt;
    logic [2:0] cmp_evt;
    logic [2:0] im_vec;
    logic mapped;
    logic [31:0] rd_mux;
    logic [2:0] hit_chctl;
    logic [2:0] hit_val_lo;
    logic [2:0] hit_val_hi;
    logic at_top;

    function automatic logic out_action(input logic [2:0] act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            tmc_pkg::ACT_SET: res = 1'b1;
            tmc_pkg::ACT_CLEAR: res = 1'b0;
            tmc_pkg::ACT_TOGGLE: res = ~cur;
            default: res = cur;
        endcase
        return res;
    endfunction : out_action

    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic prev);
        logic res;
        res = 1'b0;
        unique case (sel)
            tmc_pkg::EDGE_NONE: res = 1'b0;
            tmc_pkg::EDGE_RISE: res = now & ~prev;
            tmc_pkg::EDGE_FALL: res = ~now & prev;
            tmc_pkg::EDGE_ANY: res = now ^ prev;
        endcase
        return res;
    endfunction : edge_hit

    function automatic logic is_ch_addr(input logic [7:0] a, input logic [7:0] base,
                                        input int n);
        return a == (base + 8'(n * 4));
    endfunction : is_ch_addr

    assign running = st_r.mode != tmc_pkg::MODE_HALT;

    tmc_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick_speed_select(st_r.tick_speed_select),
        .div_sel(st_r.div),
        .run(running),
        .edge_en(edge_en)
    );

    // Zero-wait slave: read data is captured in setup so it comes from a flop
    assign pready = psel & penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata = st_r.rdata;
    assign pslverr = psel & penable & ~mapped;
    assign irq_req = st_r.timer_cpu_flag & st_r.timer_irq_enable;
    assign ch_pin_out = st_r.pout;
    assign term = st_r.chval[0];
    // Counts above a lowered terminal value also turn down instead of running on
    assign at_top = st_r.cnt >= term;

    // One decode per channel register, shared by the read and write paths
    always_comb begin
        for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            hit_chctl[i] = is_ch_addr(paddr, tmc_pkg::ADDR_CHCTL0, i);
            hit_val_lo[i] = is_ch_addr(paddr, tmc_pkg::ADDR_CHVAL0, 2 * i);
            hit_val_hi[i] = is_ch_addr(paddr, tmc_pkg::ADDR_CHVAL0, 2 * i + 1);
        end
    end

    always_comb begin
        for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            im_vec[i] = st_r.chctl[i][tmc_pkg::CH_IM_BIT];
            // Low enable means this module drives the pin
            ch_pin_oe_n[i] = ~st_r.chctl[i][tmc_pkg::CH_CMPEN_BIT];
        end
    end

    always_comb begin
        mapped = 1'b0;
        rd_mux = tmc_pkg::WORD_ZERO;
        unique case (paddr)
            tmc_pkg::ADDR_CNT_LO: begin
                mapped = 1'b1;
                rd_mux[7:0] = st_r.cnt[7:0];
            end
            tmc_pkg::ADDR_CNT_HI: begin
                mapped = 1'b1;
                rd_mux[7:0] = st_r.hi_buf;
            end
            tmc_pkg::ADDR_CTRL: begin
                mapped = 1'b1;
                rd_mux[tmc_pkg::CTRL_MODE_LSB +: 2] = st_r.mode;
                rd_mux[tmc_pkg::CTRL_DIV_LSB +: 2] = st_r.div;
                rd_mux[tmc_pkg::CTRL_WRAP_BIT] = st_r.wrap_flag;
                rd_mux[tmc_pkg::CTRL_CHF_LSB +: 3] = st_r.ch_flag;
            end
            tmc_pkg::ADDR_MASK: begin
                mapped = 1'b1;
                rd_mux[0] = st_r.wrap_irq_mask;
            end
            tmc_pkg::ADDR_CLKCTL: begin
                mapped = 1'b1;
                rd_mux[2:0] = st_r.tick_speed_select;
            end
            tmc_pkg::ADDR_IEN: begin
                mapped = 1'b1;
                rd_mux[0] = st_r.timer_irq_enable;
            end
            tmc_pkg::ADDR_CPUFLAG: begin
                mapped = 1'b1;
                rd_mux[0] = st_r.timer_cpu_flag;
            end
            default: begin
                for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
                    if (hit_chctl[i]) begin
                        mapped = 1'b1;
                        rd_mux[6:0] = st_r.chctl[i];
                    end
                    if (hit_val_lo[i]) begin
                        mapped = 1'b1;
                        rd_mux[7:0] = st_r.chval[i][7:0];
                    end
                    if (hit_val_hi[i]) begin
                        mapped = 1'b1;
                        rd_mux[7:0] = st_r.chval[i][15:8];
                    end
                end
            end
        endcase
    end

    // Counter next value and its wrap event
    always_comb begin
        cnt_step = st_r.cnt;
        wrap_evt = 1'b0;
        unique case (st_r.mode)
            tmc_pkg::MODE_HALT: cnt_step = st_r.cnt;
            tmc_pkg::MODE_FREE: begin
                cnt_step = st_r.cnt + 16'h0001;
                wrap_evt = cnt_step == tmc_pkg::CNT_FULL;
            end
            tmc_pkg::MODE_MODULO: begin
                if (st_r.cnt == term) begin
                    cnt_step = tmc_pkg::CNT_ZERO;
                end else begin
                    cnt_step = st_r.cnt + 16'h0001;
                end
                wrap_evt = cnt_step == term;
            end
            tmc_pkg::MODE_UPDOWN: begin
                if (term == tmc_pkg::CNT_ZERO) begin
                    cnt_step = tmc_pkg::CNT_ZERO;
                end else if (st_r.down || at_top) begin
                    cnt_step = st_r.cnt - 16'h0001;
                    wrap_evt = cnt_step == tmc_pkg::CNT_ZERO;
                end else begin
                    cnt_step = st_r.cnt + 16'h0001;
                end
            end
        endcase
    end

    // Channel events: compares at the counting edge, captures on any pclk while running
    always_comb begin
        for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            cap_evt[i] = running & ~st_r.chctl[i][tmc_pkg::CH_CMPEN_BIT]
                & edge_hit(st_r.chctl[i][tmc_pkg::CH_EDGE_LSB +: 2], st_r.sync1[i],
                           st_r.sprev[i]);
            cmp_evt[i] = edge_en & st_r.chctl[i][tmc_pkg::CH_CMPEN_BIT]
                & (st_r.cnt == st_r.chval[i]);
            ch_evt[i] = cap_evt[i] | cmp_evt[i];
        end
        // Channel 0 compare flags the zero turnaround in up/down mode
        if (st_r.mode == tmc_pkg::MODE_UPDOWN && st_r.chctl[0][tmc_pkg::CH_CMPEN_BIT]) begin
            ch_evt[0] = edge_en & wrap_evt;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync0 = ch_pin_in;
        st_nxt.sync1 = st_r.sync0;
        st_nxt.sprev = st_r.sync1;

        // Only a low byte read refreshes the high buffer
        if (rd_setup) begin
            st_nxt.rdata = rd_mux;
            if (paddr == tmc_pkg::ADDR_CNT_LO) begin
                // High byte caught with the low byte so the pair is coherent
                st_nxt.hi_buf = st_r.cnt[15:8];
            end
        end

        if (edge_en) begin
            st_nxt.cnt = cnt_step;
            if (st_r.mode == tmc_pkg::MODE_UPDOWN) begin
                if (wrap_evt) begin
                    st_nxt.down = 1'b0;
                end else if (term != tmc_pkg::CNT_ZERO && at_top) begin
                    st_nxt.down = 1'b1;
                end
            end else begin
                st_nxt.down = 1'b0;
            end
        end

        // Capture copies the count seen by the synchronised pin, never the raw one
        for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
            if (cap_evt[i]) begin
                st_nxt.chval[i] = st_r.cnt;
            end
            if (cmp_evt[i]) begin
                st_nxt.pout[i] = out_action(st_r.chctl[i][tmc_pkg::CH_ACT_LSB +: 3],
                                            st_r.pout[i]);
            end
        end

        // Writes to the high count byte are dropped: it only mirrors the buffer
        if (wr_acc) begin
            unique case (paddr)
                tmc_pkg::ADDR_CNT_LO: begin
                    st_nxt.cnt = tmc_pkg::CNT_ZERO;
                    st_nxt.down = 1'b0;
                end
                tmc_pkg::ADDR_CTRL: begin
                    st_nxt.mode = pwdata[tmc_pkg::CTRL_MODE_LSB +: 2];
                    st_nxt.div = pwdata[tmc_pkg::CTRL_DIV_LSB +: 2];
                    if (!pwdata[tmc_pkg::CTRL_WRAP_BIT]) begin
                        st_nxt.wrap_flag = 1'b0;
                    end
                    st_nxt.ch_flag = st_r.ch_flag & pwdata[tmc_pkg::CTRL_CHF_LSB +: 3];
                end
                tmc_pkg::ADDR_MASK: st_nxt.wrap_irq_mask = pwdata[0];
                tmc_pkg::ADDR_CLKCTL: st_nxt.tick_speed_select = pwdata[2:0];
                tmc_pkg::ADDR_IEN: st_nxt.timer_irq_enable = pwdata[0];
                tmc_pkg::ADDR_CPUFLAG: begin
                    if (!pwdata[0]) begin
                        st_nxt.timer_cpu_flag = 1'b0;
                    end
                end
                default: begin
                    for (int i = 0; i < tmc_pkg::NUM_CH; i++) begin
                        if (hit_chctl[i]) begin
                            st_nxt.chctl[i] = pwdata[6:0];
                        end
                        // Low byte waits in a buffer until the high byte lands
                        if (hit_val_lo[i]) begin
                            st_nxt.lo_buf[i] = pwdata[7:0];
                        end
                        if (hit_val_hi[i]) begin
                            st_nxt.chval[i] = {pwdata[7:0], st_r.lo_buf[i]};
                        end
                    end
                end
            endcase
        end

        // Hardware sets win over software clears
        if (edge_en && wrap_evt) begin
            st_nxt.wrap_flag = 1'b1;
        end
        st_nxt.ch_flag = st_nxt.ch_flag | ch_evt;
        // Level term: unmasking a pending flag raises the CPU flag too
        if ((st_r.wrap_flag && st_r.wrap_irq_mask) || |(st_r.ch_flag & im_vec)) begin
            st_nxt.timer_cpu_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : tmc_timer

/* File: test/tmc_timer_checker.sv */
`timescale 1ns/1ps
module tmc_timer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] ch_pin_in,
    input wire logic [2:0] ch_pin_out,
    input wire logic [2:0] ch_pin_oe_n,
    input wire logic irq_req
);
    logic bad_addr;
    logic acc;
    assign bad_addr = (paddr > 8'h3C) || (paddr[1:0] != 2'h0);
    assign acc = psel && penable;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_in_access: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_ready_outside: assert property (!acc |-> !pready)
        else $error("pready high outside access phase");
    a_err_on_hole: assert property (acc && bad_addr |-> pslverr)
        else $error("unmapped access not refused");
    a_err_on_map: assert property (acc && !bad_addr |-> !pslverr)
        else $error("mapped access refused");
    a_hole_reads_zero: assert property (psel && !penable && !pwrite && bad_addr
        |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_irq_enable_off: assert property (acc && pwrite && paddr == tmc_pkg::ADDR_IEN
        && !pwdata[0] |=> !irq_req [*3]) else $error("request without enable");
    a_pin_release: assert property (acc && pwrite && paddr == tmc_pkg::ADDR_CHCTL0
        && !pwdata[2] |=> ch_pin_oe_n[0]) else $error("pin still driven");
endmodule : tmc_timer_checker

bind tmc_timer tmc_timer_checker u_tmc_timer_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_pin_in(ch_pin_in),
    .ch_pin_out(ch_pin_out), .ch_pin_oe_n(ch_pin_oe_n), .irq_req(irq_req));

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] ch_pin_in, ch_pin_out, ch_pin_oe_n;
    int errors, samples_checked, seed, n;
    int divs[5] = '{1, 8, 32, 128, 2};
    logic [7:0] lo_q[$], hi_q[$];
    string nm_q[$];

    tmc_timer u_tmc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
        .ch_pin_oe_n(ch_pin_oe_n), .irq_req(irq_req));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check(string nm, logic [7:0] lo, logic [7:0] hi, logic [7:0] seen);
        samples_checked++;
        if ((seen >= lo && seen <= hi) !== 1'b1) begin
            errors++;
            $display("BAD %s expected %h..%h seen %h", nm, lo, hi, seen);
        end
    endtask : check

    // Ranges, not exact counts, where the prescaler phase at start is open
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (nm_q.size() == 0) begin
                errors++;
                $display("BAD read expected none seen %h", prdata);
            end else begin
                check(nm_q.pop_front(), lo_q.pop_front(), hi_q.pop_front(), prdata[7:0]);
            end
        end
    end

    always @(posedge pclk) ch_pin_in <= 3'($random(seed));

    // An idle cycle follows each transfer so psel is never driven twice in a step
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("BAD pready expected 1 seen %b", pready);
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus

    task automatic rd(string nm, logic [7:0] a, logic [7:0] lo, logic [7:0] hi);
        nm_q.push_back(nm);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic run(logic [31:0] ctl, int cyc);
        bus(1'b1, tmc_pkg::ADDR_CNT_LO, $random(seed));
        bus(1'b1, tmc_pkg::ADDR_CTRL, ctl);
        repeat (cyc) @(posedge pclk);
    endtask : run

    initial begin
        seed = 98;
        errors = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("ctrl reset", tmc_pkg::ADDR_CTRL, 8'h00, 8'h00);
        rd("unmapped", 8'h40, 8'h00, 8'h00);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, tmc_pkg::ADDR_CHCTL0 + 8'(4 * i), 32'h0000_0004);
            check("pin drive", 8'h00, 8'h00, 8'(ch_pin_oe_n[i]));
            bus(1'b1, tmc_pkg::ADDR_CHCTL0 + 8'(4 * i), 32'h0000_0000);
            check("pin release", 8'h01, 8'h01, 8'(ch_pin_oe_n[i]));
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, tmc_pkg::ADDR_CLKCTL, 32'(i / 4));
            run(32'(4 * (i % 4) + 1), 100 * divs[i]);
            bus(1'b1, tmc_pkg::ADDR_CTRL, 32'(4 * (i % 4)));
            rd("scaled count", tmc_pkg::ADDR_CNT_LO, 8'h61, 8'h69);
        end
        bus(1'b1, tmc_pkg::ADDR_CLKCTL, 32'h0000_0000);
        run(32'h0000_0001, 200);
        rd("live low", tmc_pkg::ADDR_CNT_LO, 8'hC0, 8'hD8);
        repeat (100) @(posedge pclk);
        rd("buffered high", tmc_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0000);
        run(32'h0000_0000, 20);
        rd("cleared low", tmc_pkg::ADDR_CNT_LO, 8'h00, 8'h00);
        rd("cleared high", tmc_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        bus(1'b1, tmc_pkg::ADDR_CHVAL0 + 8'h08, 32'h0000_0003);
        bus(1'b1, tmc_pkg::ADDR_CHVAL0 + 8'h0C, 32'h0000_0000);
        bus(1'b1, tmc_pkg::ADDR_CHCTL0 + 8'h04, 32'h0000_0004);
        check("compare idle", 8'h00, 8'h00, 8'(ch_pin_out[1]));
        bus(1'b1, tmc_pkg::ADDR_CHVAL0, 32'h0000_0005);
        bus(1'b1, tmc_pkg::ADDR_CHVAL0 + 8'h04, 32'h0000_0000);
        bus(1'b1, tmc_pkg::ADDR_IEN, 32'h0000_0001);
        bus(1'b1, tmc_pkg::ADDR_MASK, 32'h0000_0001);
        run(32'h0000_0002, 0);
        for (int i = 0; i < 6; i++) begin
            repeat (i) @(posedge pclk);
            rd("modulo low", tmc_pkg::ADDR_CNT_LO, 8'h00, 8'h05);
        end
        rd("modulo high", tmc_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        check("irq", 8'h01, 8'h01, 8'(irq_req));
        check("compare out", 8'h01, 8'h01, 8'(ch_pin_out[1]));
        bus(1'b1, tmc_pkg::ADDR_CHCTL0 + 8'h04, 32'h0000_0000);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0010);
        rd("flag after one", tmc_pkg::ADDR_CTRL, 8'h10, 8'h10);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd("flag after zero", tmc_pkg::ADDR_CTRL, 8'h00, 8'h00);
        check("irq sticky", 8'h01, 8'h01, 8'(irq_req));
        bus(1'b1, tmc_pkg::ADDR_CPUFLAG, 32'h0000_0000);
        check("irq cleared", 8'h00, 8'h00, 8'(irq_req));
        bus(1'b1, tmc_pkg::ADDR_CHVAL0, 32'h0000_0040);
        bus(1'b1, tmc_pkg::ADDR_CHVAL0 + 8'h04, 32'h0000_0000);
        bus(1'b1, tmc_pkg::ADDR_MASK, 32'h0000_0000);
        run(32'h0000_0003, 67);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0010);
        rd("no flag at top", tmc_pkg::ADDR_CTRL, 8'h00, 8'h00);
        rd("down count", tmc_pkg::ADDR_CNT_LO, 8'h36, 8'h3E);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (100) @(posedge pclk);
        check("irq masked", 8'h00, 8'h00, 8'(irq_req));
        bus(1'b1, tmc_pkg::ADDR_MASK, 32'h0000_0001);
        @(posedge pclk);
        check("irq unmasked", 8'h01, 8'h01, 8'(irq_req));
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0010);
        rd("flag at zero", tmc_pkg::ADDR_CTRL, 8'h10, 8'h10);
        rd("updown low", tmc_pkg::ADDR_CNT_LO, 8'h00, 8'h40);
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, tmc_pkg::ADDR_CPUFLAG, 32'h0000_0000);
        run(32'h0000_0001, 0);
        n = 0;
        while (irq_req !== 1'b1 && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        samples_checked++;
        if (n < 65530 || n > 65540) begin
            errors++;
            $display("BAD wrap cycles expected 65535 seen %0d", n);
        end
        bus(1'b1, tmc_pkg::ADDR_CTRL, 32'h0000_0010);
        rd("free flag", tmc_pkg::ADDR_CTRL, 8'h10, 8'h10);
        rd("wrapped low", tmc_pkg::ADDR_CNT_LO, 8'h00, 8'h20);
        rd("wrapped high", tmc_pkg::ADDR_CNT_HI, 8'h00, 8'h00);
        bus(1'b1, tmc_pkg::ADDR_IEN, 32'h0000_0000);
        check("irq disabled", 8'h00, 8'h00, 8'(irq_req));
        repeat (4) @(posedge pclk);
        if (nm_q.size() != 0) begin
            errors++;
            $display("BAD reads expected 0 pending seen %0d", nm_q.size());
        end
        print_verdict();
    end
endmodule : testbench
